/* bms_consts.svh */
// Summary of operation
// [RULE1] Enable below wake level keeps supply and switching off.
// [RULE2] Enable between wake and precision levels powers supply, switch node idle.
// [RULE3] Above precision enable, switch only while input supply exceeds 3 V.
// [RULE4] On-time or off-time limit lowers switching frequency to stay regulated.
// [RULE5] Automatic mode uses light-load pulse skipping with diode emulation.
// [RULE6] Forced fixed-frequency mode disables diode emulation, allows reverse current.
// [RULE7] Synchronized mode follows external clock unless on/off-time limits prevent it.
// [RULE8] While synchronized, behave as forced fixed-frequency, diode emulation off.
// [RULE9] Level-dependent control ignores external clocks, never synchronizes.
// [RULE10] Ground: auto with spread; mid: forced with spread; top: forced without.
// [RULE11] Level selection applies only after the dwell time at one level.
// [RULE12] Spread spectrum off during frequency foldback, restored afterwards.
// [RULE13] 100 kilohm strap to ground fixes auto mode without spread spectrum.
// [RULE14] Controller drives a valid sync pulse train to start pulse control.
// [RULE15] Pulse control begins when fourth pulse of a valid train completes.
// [RULE16] Pulse control persists until restart; only restart returns level control.
// [RULE17] Enable input is always driven to a defined level.
// [RULE18] Pin holds one level at least 16.5 us before selection accepted.
// [RULE19] Low excursion must last at least 100 ns to count as pulse.
// [RULE20] Synchronized mode entered after valid sync present 2048 cycles.
// [RULE21] Mode decisions use one-hot comparator code: ground, mid, top, strap.
`ifndef BMS_CONSTS_SVH
`define BMS_CONSTS_SVH

`define BMS_CLK_MHZ         40
`define BMS_T_MODE_NS       16500
`define BMS_T_MODE_CYC      ((`BMS_T_MODE_NS * `BMS_CLK_MHZ + 999) / 1000)
`define BMS_T_PULSE_L_NS    100
`define BMS_T_PULSE_L_CYC   ((`BMS_T_PULSE_L_NS * `BMS_CLK_MHZ + 999) / 1000)
`define BMS_T_SYNC_NS       8000
`define BMS_T_SYNC_CYC      ((`BMS_T_SYNC_NS * `BMS_CLK_MHZ) / 1000)
`define BMS_ENTRY_PULSES    4
`define BMS_LOCK_PULSES     2048

`define BMS_CODE_GND        4'h1
`define BMS_CODE_MID        4'h2
`define BMS_CODE_TOP        4'h4
`define BMS_CODE_STRAP      4'h8

`define BMS_REG_CTRL        8'h00
`define BMS_REG_STATUS      8'h04
`define BMS_CTRL_SS_INH     0
`define BMS_CTRL_RESET      32'h0000_0000
`define BMS_ST_PWR_LSB      0
`define BMS_ST_MODE_LSB     2
`define BMS_ST_PULSE        4
`define BMS_ST_SS           5
`define BMS_ST_FOLD         6
`define BMS_ST_STRAP        7
`define BMS_ST_FOLLOW       8
`define BMS_RESP_OKAY       2'h0
`define BMS_RESP_SLVERR     2'h2

`endif

/* bms_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none

module bms_pin_model (
    input  wire logic  ref_clk_i,
    output logic       mode_pin_o,
    output logic [3:0] pin_code_o
);
    initial
    begin
        mode_pin_o = 1'b0;
        pin_code_o = 4'h1;
    end

    ////////////////////////////////////////////////////////////////
    // static level, held for n cycles
    task automatic lvl(input logic [3:0] code, input int n);
        @(posedge ref_clk_i);
        pin_code_o <= code;
        mode_pin_o <= (code == 4'h2) || (code == 4'h4);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // sync train, 200 ns period, 125 ns low
    task automatic pulses(input int n);
        repeat (n)
        begin
            mode_pin_o <= 1'b0;
            pin_code_o <= 4'h1;
            repeat (5) @(posedge ref_clk_i);
            mode_pin_o <= 1'b1;
            pin_code_o <= 4'h4;
            repeat (3) @(posedge ref_clk_i);
        end
    endtask
endmodule

`default_nettype wire

/* bms_pkg.sv */
package bms_pkg;

    typedef enum logic [1:0]
    {
        bms_shut = 2'h0,
        bms_stby = 2'h1,
        bms_run  = 2'h3
    } bms_pwr_e;

    typedef enum logic [1:0]
    {
        bms_auto   = 2'h0,
        bms_forced = 2'h1,
        bms_sync   = 2'h3
    } bms_mode_e;

endpackage

/* bms_sync3.sv */
`timescale 1ns/100ps
`default_nettype none

module bms_sync3 #(
    parameter int W = 8
) (
    input  wire logic         ref_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         clk_en_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic out_q;
            // change accepted once second and third stages agree
            always_ff @(posedge ref_clk_i)
            begin
                if (sys_rst_i)
                begin
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    out_q <= 1'b0;
                end
                else if (clk_en_i)
                begin
                    s1_q <= async_i[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                    begin
                        out_q <= s3_q;
                    end
                end
            end
            assign sync_o[g] = out_q;
        end
    endgenerate

endmodule

`default_nettype wire

/* bms_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bms_consts.svh"

module bms_top
    import bms_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    input  wire logic        en_wake_i,
    input  wire logic        en_prec_i,
    input  wire logic        vin_ok_i,
    input  wire logic        mode_pin_i,
    input  wire logic [3:0]  pin_code_i,
    input  wire logic        ton_limit_i,
    input  wire logic        toff_limit_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic             vcc_en_o,
    output logic             sw_en_o,
    output logic             pfm_en_o,
    output logic             diode_emul_o,
    output logic             ss_en_o,
    output logic             fold_o,
    output logic             sync_follow_o,
    output logic             pulse_ctrl_o,
    output logic [1:0]       mode_o
);

    localparam int T_MODE_M1 = `BMS_T_MODE_CYC - 1;

    logic [7:0]  sync_s;
    logic        wake_s;
    logic        prec_s;
    logic        vin_s;
    logic        lvl_s;
    logic [3:0]  code_s;
    logic        restart;
    logic        lim;
    logic        fall;
    logic        rise;
    logic        valid_pulse;
    logic        stale;
    logic        lvl_apply;
    logic        pls_apply;
    bms_pwr_e    pwr_q;
    bms_mode_e   mode_q;
    logic        ss_sel_q;
    logic        strap_fixed_q;
    logic        pulse_q;
    logic        lvl_prev_q;
    logic        high_ok_q;
    logic [9:0]  run_cnt_q;
    logic [11:0] train_cnt_q;
    logic [1:0]  burst_cnt_q;
    logic [3:0]  code_prev_q;
    logic [9:0]  dwell_cnt_q;
    logic        pfm_q;
    logic        de_q;
    logic        ss_q;
    logic        fold_q;
    logic        follow_q;
    logic [31:0] ctrl_q;
    logic        aw_hold_q;
    logic [7:0]  awaddr_q;
    logic        w_hold_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] status;

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    bms_sync3 #(
        .W (8)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .clk_en_i  (clk_en_i),
        .async_i   ({pin_code_i, mode_pin_i, vin_ok_i, en_prec_i, en_wake_i}),
        .sync_o    (sync_s)
    );

    assign wake_s = sync_s[0];
    assign prec_s = sync_s[1];
    assign vin_s  = sync_s[2];
    assign lvl_s  = sync_s[3];
    assign code_s = sync_s[7:4];

    ////////////////////////////////////////////////////////////////////////////////
    // power sequencing

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            pwr_q <= bms_shut;
        end
        else if (clk_en_i)
        begin
            unique case (pwr_q)
                bms_shut:
                begin
                    if (wake_s)
                    begin
                        pwr_q <= bms_stby; // RULE2
                    end
                end
                bms_stby:
                begin
                    if (!wake_s)
                    begin
                        pwr_q <= bms_shut; // RULE1
                    end
                    else if (prec_s && vin_s)
                    begin
                        pwr_q <= bms_run; // RULE3
                    end
                end
                bms_run:
                begin
                    if (!wake_s)
                    begin
                        pwr_q <= bms_shut; // RULE1
                    end
                    else if (!(prec_s && vin_s))
                    begin
                        pwr_q <= bms_stby; // RULE3
                    end
                end
                default:
                begin
                    pwr_q <= bms_shut;
                end
            endcase
        end
    end

    assign vcc_en_o = pwr_q[0];
    assign sw_en_o  = pwr_q[1];
    assign restart  = (pwr_q == bms_shut);
    assign lim      = ton_limit_i || toff_limit_i;

    ////////////////////////////////////////////////////////////////////////////////
    // pulse timing on the mode pin

    assign fall  = lvl_prev_q && !lvl_s;
    assign rise  = !lvl_prev_q && lvl_s;
    assign stale = (run_cnt_q >= 10'(`BMS_T_SYNC_CYC));
    assign valid_pulse = rise && high_ok_q
        && (run_cnt_q >= 10'(`BMS_T_PULSE_L_CYC - 1)) // RULE19
        && (run_cnt_q < 10'(`BMS_T_SYNC_CYC));

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            lvl_prev_q <= 1'b0;
            run_cnt_q  <= 10'h000;
            high_ok_q  <= 1'b0;
        end
        else if (clk_en_i)
        begin
            lvl_prev_q <= lvl_s;
            if (fall || rise)
            begin
                run_cnt_q <= 10'h000;
            end
            else if (run_cnt_q != 10'h3FF)
            begin
                run_cnt_q <= run_cnt_q + 10'h001;
            end
            if (fall)
            begin
                high_ok_q <= (run_cnt_q < 10'(`BMS_T_SYNC_CYC));
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            train_cnt_q <= 12'h000;
        end
        else if (clk_en_i)
        begin
            if (stale || (rise && !valid_pulse))
            begin
                train_cnt_q <= 12'h000;
            end
            else if (valid_pulse && train_cnt_q != 12'(`BMS_LOCK_PULSES))
            begin
                train_cnt_q <= train_cnt_q + 12'h001;
            end
        end
    end

    // entry into pulse control, left only by restart
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            pulse_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (restart)
            begin
                pulse_q <= 1'b0; // RULE16
            end
            else if (valid_pulse && train_cnt_q == 12'(`BMS_ENTRY_PULSES - 1))
            begin
                pulse_q <= 1'b1; // RULE15
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            burst_cnt_q <= 2'h0;
        end
        else if (clk_en_i)
        begin
            if (pls_apply)
            begin
                burst_cnt_q <= 2'h0;
            end
            else if (valid_pulse && burst_cnt_q != 2'h3)
            begin
                burst_cnt_q <= burst_cnt_q + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // level dwell on the comparator code

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            code_prev_q <= 4'h0;
            dwell_cnt_q <= 10'h000;
        end
        else if (clk_en_i)
        begin
            code_prev_q <= code_s;
            if (code_s != code_prev_q)
            begin
                dwell_cnt_q <= 10'h000;
            end
            else if (dwell_cnt_q != 10'h3FF)
            begin
                dwell_cnt_q <= dwell_cnt_q + 10'h001;
            end
        end
    end

    assign lvl_apply = !pulse_q && !strap_fixed_q && !restart
        && (dwell_cnt_q == 10'(T_MODE_M1)); // RULE11 RULE18 RULE21
    assign pls_apply = pulse_q && (run_cnt_q == 10'(T_MODE_M1)); // RULE18

    ////////////////////////////////////////////////////////////////////////////////
    // mode selection

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            mode_q        <= bms_auto;
            ss_sel_q      <= 1'b1;
            strap_fixed_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (restart)
            begin
                mode_q        <= bms_auto;
                ss_sel_q      <= 1'b1;
                strap_fixed_q <= 1'b0;
            end
            else if (lvl_apply)
            begin
                case (code_s) // RULE10 RULE9
                    `BMS_CODE_GND:
                    begin
                        mode_q   <= bms_auto;
                        ss_sel_q <= 1'b1;
                    end
                    `BMS_CODE_MID:
                    begin
                        mode_q   <= bms_forced;
                        ss_sel_q <= 1'b1;
                    end
                    `BMS_CODE_TOP:
                    begin
                        mode_q   <= bms_forced;
                        ss_sel_q <= 1'b0;
                    end
                    `BMS_CODE_STRAP:
                    begin
                        mode_q        <= bms_auto; // RULE13
                        ss_sel_q      <= 1'b0;
                        strap_fixed_q <= 1'b1;
                    end
                    default:
                    begin
                        mode_q <= mode_q;
                    end
                endcase
            end
            else if (pulse_q && valid_pulse
                && train_cnt_q == 12'(`BMS_LOCK_PULSES - 1))
            begin
                mode_q   <= bms_sync; // RULE20
                ss_sel_q <= 1'b0;
            end
            else if (pls_apply)
            begin
                mode_q   <= lvl_s ? bms_forced : bms_auto;
                ss_sel_q <= (burst_cnt_q != 2'h2);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // converter controls

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            pfm_q    <= 1'b0;
            de_q     <= 1'b1;
            ss_q     <= 1'b0;
            fold_q   <= 1'b0;
            follow_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            pfm_q    <= sw_en_o && (mode_q == bms_auto); // RULE5
            de_q     <= (mode_q == bms_auto); // RULE6 RULE8
            fold_q   <= sw_en_o && lim; // RULE4
            ss_q     <= sw_en_o && ss_sel_q && !lim && !ctrl_q[`BMS_CTRL_SS_INH]; // RULE12
            follow_q <= sw_en_o && (mode_q == bms_sync) && !lim; // RULE7
        end
    end

    assign pfm_en_o      = pfm_q;
    assign diode_emul_o  = de_q;
    assign ss_en_o       = ss_q;
    assign fold_o        = fold_q;
    assign sync_follow_o = follow_q;
    assign pulse_ctrl_o  = pulse_q;
    assign mode_o        = mode_q;

    ////////////////////////////////////////////////////////////////////////////////
    // register slave

    assign status = {23'h0, follow_q, strap_fixed_q, fold_q, ss_q, pulse_q, mode_q, pwr_q};

    assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
    assign s_axi_wready_o  = !w_hold_q && !bvalid_q;
    assign s_axi_arready_o = !rvalid_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= 8'h00;
            w_hold_q  <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `BMS_RESP_OKAY;
            ctrl_q    <= `BMS_CTRL_RESET;
        end
        else if (clk_en_i)
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata_i;
                wstrb_q  <= s_axi_wstrb_i;
            end
            if (aw_hold_q && w_hold_q && !bvalid_q)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= `BMS_RESP_OKAY;
                if (awaddr_q == `BMS_REG_CTRL)
                begin
                    if (wstrb_q[0])
                    begin
                        ctrl_q[0] <= wdata_q[0];
                    end
                end
                else if (awaddr_q != `BMS_REG_STATUS)
                begin
                    bresp_q <= `BMS_RESP_SLVERR;
                end
            end
            else if (bvalid_q && s_axi_bready_i)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `BMS_RESP_OKAY;
        end
        else if (clk_en_i)
        begin
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                rvalid_q <= 1'b1;
                rresp_q  <= `BMS_RESP_OKAY;
                if (s_axi_araddr_i == `BMS_REG_CTRL)
                begin
                    rdata_q <= ctrl_q;
                end
                else if (s_axi_araddr_i == `BMS_REG_STATUS)
                begin
                    rdata_q <= status;
                end
                else
                begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `BMS_RESP_SLVERR;
                end
            end
            else if (rvalid_q && s_axi_rready_i)
            begin
                rvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_shut;
        (pwr_q == bms_shut) |-> !vcc_en_o && !sw_en_o;
    endproperty
    a_shut: assert property (p_shut) else $error("switching in shutdown"); // RULE1

    property p_stby;
        $past(clk_en_i) && (pwr_q == bms_stby) |-> vcc_en_o && !sw_en_o && $past(wake_s);
    endproperty
    a_stby: assert property (p_stby) else $error("standby wrong"); // RULE2

    property p_run;
        $past(clk_en_i) && sw_en_o |-> $past(prec_s) && $past(vin_s) && $past(wake_s);
    endproperty
    a_run: assert property (p_run) else $error("switching without enable"); // RULE3

    property p_fold;
        clk_en_i && sw_en_o && lim |=> fold_o && !ss_en_o && !sync_follow_o;
    endproperty
    a_fold: assert property (p_fold) else $error("foldback missed"); // RULE4

    property p_auto;
        clk_en_i && sw_en_o && (mode_q == bms_auto) |=> pfm_en_o && diode_emul_o;
    endproperty
    a_auto: assert property (p_auto) else $error("auto mode outputs wrong"); // RULE5

    property p_forced;
        clk_en_i && (mode_q != bms_auto) |=> !diode_emul_o && !pfm_en_o;
    endproperty
    a_forced: assert property (p_forced) else $error("diode emulation in fixed mode"); // RULE6

    property p_sync;
        sync_follow_o |-> $past(mode_q) == bms_sync && !$past(lim);
    endproperty
    a_sync: assert property (p_sync) else $error("follow without sync"); // RULE7

    property p_lvl;
        !pulse_q |-> mode_q != bms_sync;
    endproperty
    a_lvl: assert property (p_lvl) else $error("sync under level control"); // RULE9

    property p_dwell;
        $past(clk_en_i) && !$past(pulse_q) && !$past(restart)
            && ($past(mode_q) != mode_q || $past(ss_sel_q) != ss_sel_q)
            |-> $past(dwell_cnt_q) == 10'(T_MODE_M1);
    endproperty
    a_dwell: assert property (p_dwell) else $error("mode taken before dwell"); // RULE11

    property p_ss;
        fold_o |-> !ss_en_o;
    endproperty
    a_ss: assert property (p_ss) else $error("spread during foldback"); // RULE12

    property p_strap;
        strap_fixed_q && !pulse_q |-> mode_q == bms_auto && !ss_sel_q;
    endproperty
    a_strap: assert property (p_strap) else $error("strap choice changed"); // RULE13

    property p_fourth;
        $rose(pulse_q) |-> $past(train_cnt_q) == 12'h003 && $past(rise);
    endproperty
    a_fourth: assert property (p_fourth) else $error("pulse entry not on fourth"); // RULE15

    property p_stay;
        clk_en_i && pulse_q && !restart |=> pulse_q;
    endproperty
    a_stay: assert property (p_stay) else $error("left pulse control"); // RULE16

    property p_pulse;
        train_cnt_q > $past(train_cnt_q)
            |-> $past(run_cnt_q) >= 10'(`BMS_T_PULSE_L_CYC - 1) && !$past(lvl_prev_q);
    endproperty
    a_pulse: assert property (p_pulse) else $error("short pulse counted"); // RULE19

    property p_lock;
        (mode_q == bms_sync) && ($past(mode_q) != bms_sync)
            |-> $past(train_cnt_q) == 12'h7FF;
    endproperty
    a_lock: assert property (p_lock) else $error("sync before lock count"); // RULE20

endmodule

`default_nettype wire

/* bms_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module bms_top_tb;
    logic        ref_clk_i, sys_rst_i, clk_en_i, en_wake_i, en_prec_i, vin_ok_i;
    logic        mode_pin_i, ton_limit_i, toff_limit_i, vcc_en_o, sw_en_o, pfm_en_o;
    logic        diode_emul_o, ss_en_o, fold_o, sync_follow_o, pulse_ctrl_o;
    logic [3:0]  pin_code_i, s_axi_wstrb_i;
    logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, mode_o, rs;
    logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
    logic        s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic        s_axi_arready_o, s_axi_rvalid_o;
    int          mismatches, n_checks;

    bms_top DUT (.ref_clk_i, .sys_rst_i, .clk_en_i, .en_wake_i, .en_prec_i, .vin_ok_i,
        .mode_pin_i, .pin_code_i, .ton_limit_i, .toff_limit_i, .s_axi_awaddr_i,
        .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
        .s_axi_rready_i, .vcc_en_o, .sw_en_o, .pfm_en_o, .diode_emul_o, .ss_en_o, .fold_o,
        .sync_follow_o, .pulse_ctrl_o, .mode_o);
    bms_pin_model PM (.ref_clk_i, .mode_pin_o(mode_pin_i), .pin_code_o(pin_code_i));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        s_axi_awaddr_i  <= a;
        s_axi_wdata_i   <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        s_axi_bready_i  <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end
        while (s_axi_bvalid_o !== 1'b1);
        s_axi_bready_i <= 1'b0;
        rs = s_axi_bresp_o;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk_i);
        s_axi_araddr_i  <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i  <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end
        while (s_axi_rvalid_o !== 1'b1);
        s_axi_rready_i <= 1'b0;
        rd = s_axi_rdata_o;
        rs = s_axi_rresp_o;
    endtask

    task automatic close_out();
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        cyc(40000);
        mismatches++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        {mismatches, n_checks, en_wake_i, en_prec_i, vin_ok_i, ton_limit_i, toff_limit_i} = '0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
        s_axi_wstrb_i = 4'hF;
        clk_en_i = 1'b1;
        sys_rst_i = 1'b1;
        cyc(8);
        sys_rst_i <= 1'b0;
        cyc(10);
        chk("vcc_sw", 2'h0, {vcc_en_o, sw_en_o});
        en_wake_i <= 1'b1;
        en_prec_i <= 1'b1;
        cyc(10);
        chk("vcc_sw", 2'h2, {vcc_en_o, sw_en_o});
        vin_ok_i <= 1'b1;
        cyc(10);
        chk("vcc_sw", 2'h3, {vcc_en_o, sw_en_o});
        PM.lvl(4'h2, 600);
        chk("mode", 2'h0, mode_o);
        cyc(80);
        chk("mode_de_ss", 4'h5, {mode_o, diode_emul_o, ss_en_o});
        PM.lvl(4'h4, 700);
        chk("mode_ss", 3'h2, {mode_o, ss_en_o});
        PM.lvl(4'h1, 700);
        chk("mode_pfm_de_ss", 5'h07, {mode_o, pfm_en_o, diode_emul_o, ss_en_o});
        ton_limit_i <= 1'b1;
        cyc(3);
        chk("fold_ss", 2'h2, {fold_o, ss_en_o});
        ton_limit_i <= 1'b0;
        cyc(3);
        chk("fold_ss", 2'h1, {fold_o, ss_en_o});
        wr(8'h00, 32'h0000_0001);
        cyc(3);
        chk("ss_inhibit", 2'h0, {rs, ss_en_o});
        wr(8'h00, 32'h0000_0000);
        cyc(3);
        rdr(8'h04);
        chk("status", 32'h0000_0023, rd);
        rdr(8'h10);
        chk("unmapped_rd", 32'h0000_0000, rd);
        chk("unmapped_rresp", 2'h2, rs);
        wr(8'h10, 32'h0000_0001);
        chk("unmapped_wr", 2'h2, rs);
        PM.pulses(4);
        chk("pulse_ctrl", 1'b0, pulse_ctrl_o);
        PM.pulses(1);
        cyc(8);
        chk("pulse_ctrl", 1'b1, pulse_ctrl_o);
        PM.pulses(2060);
        cyc(8);
        chk("sync", 5'h1C, {mode_o, sync_follow_o, diode_emul_o, ss_en_o});
        PM.lvl(4'h1, 700);
        chk("mode_pc", 3'h1, {mode_o, pulse_ctrl_o});
        en_wake_i <= 1'b0;
        cyc(10);
        chk("vcc_pc", 2'h0, {vcc_en_o, pulse_ctrl_o});
        en_wake_i <= 1'b1;
        PM.lvl(4'h8, 700);
        chk("strap", 3'h0, {mode_o, ss_en_o});
        PM.lvl(4'h2, 700);
        chk("strap_fixed", 3'h0, {mode_o, ss_en_o});
        close_out();
    end
endmodule

`default_nettype wire
